// ### logic/cksd_clock_control.v
// Clock source decode, system clock divider and start-up timing with AXI4-Lite registers
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module cksd_clock_control #(
  parameter WDT_SHORT = 17'd4096,
  parameter WDT_LONG = 17'd65536,
  parameter [3:0] SRC_FUSE_INIT = 4'h1,
  parameter [1:0] SUT_FUSE_INIT = 2'h2,
  parameter AMP_FUSE_INIT = 1'b1
) (
  input wire aclk,
  input wire aresetn,
  input wire src_clk_in,
  input wire wdt_osc_in,
  input wire wake_req,
  input wire sleep_req,
  input wire adc_halt_req,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg core_clk_en,
  output reg io_clk_en,
  output reg program_memory_clk_en,
  output reg converter_clk_en,
  output reg async_detect_en,
  output reg async_timer_clk_en,
  output reg full_swing_amp,
  output reg [2:0] clock_source,
  output reg cpu_run
);
`include "cksd_defines.vh"

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers; source and watchdog oscillator are foreign edges
  reg [1:0] src_s_r;
  reg [1:0] wdt_s_r;
  reg [1:0] wake_s_r;
  reg src_d_r;
  reg wdt_d_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_s_r <= 2'b00;
      wdt_s_r <= 2'b00;
      wake_s_r <= 2'b00;
      src_d_r <= 1'b0;
      wdt_d_r <= 1'b0;
    end else begin
      src_s_r <= {src_s_r[0], src_clk_in};
      wdt_s_r <= {wdt_s_r[0], wdt_osc_in};
      wake_s_r <= {wake_s_r[0], wake_req};
      src_d_r <= src_s_r[1];
      wdt_d_r <= wdt_s_r[1];
    end
  end
  wire src_tick = src_s_r[1] & ~src_d_r;
  wire wdt_tick = wdt_s_r[1] & ~wdt_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Fuse image, latched one cycle after reset release; ones are unprogrammed
  reg [3:0] src_fuse_r;
  reg [1:0] sut_fuse_r;
  reg amp_fuse_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_fuse_r <= `CKSD_SRC_DEFAULT; // [RULE_11]
      sut_fuse_r <= `CKSD_SUT_DEFAULT; // [RULE_11]
      amp_fuse_r <= 1'b1;
    end else begin
      src_fuse_r <= SRC_FUSE_INIT;
      sut_fuse_r <= SUT_FUSE_INIT;
      amp_fuse_r <= AMP_FUSE_INIT;
    end
  end
  wire amp_programmed = ~amp_fuse_r; // [RULE_08]
  wire [2:0] range_fuses = src_fuse_r[3:1];
  wire is_xtal = (src_fuse_r >= 4'ha); // [RULE_07]

  // Source class: 0 ext clock, 1 internal RC, 2 ext RC, 3 low-freq xtal, 4 xtal
  reg [2:0] src_class;
  reg [1:0] xtal_band;
  always @* begin
    if (is_xtal) begin // [RULE_07]
      src_class = 3'd4;
    end else if (src_fuse_r == 4'h9) begin
      src_class = 3'd3;
    end else if (src_fuse_r >= 4'h5) begin
      src_class = 3'd2;
    end else if (src_fuse_r >= 4'h1) begin
      src_class = 3'd1;
    end else begin
      src_class = 3'd0;
    end
    // Band 0: 1 MHz up, 1: 0.4-0.9, 2: 0.9-3.0, 3: 3.0-8.0
    if (amp_programmed || !is_xtal) begin // [RULE_13]
      xtal_band = 2'd0;
    end else if (range_fuses == 3'b101) begin
      xtal_band = 2'd1;
    end else if (range_fuses == 3'b110) begin
      xtal_band = 2'd2;
    end else begin
      xtal_band = 2'd3;
    end
  end

  // Start-up cycles and reset delay per source (0 none, 1 short, 2 long)
  reg [14:0] su_cycles;
  reg [1:0] rst_delay;
  always @* begin
    su_cycles = `CKSD_CK_6;
    rst_delay = 2'd0;
    case (src_class)
      3'd4: begin
        case ({src_fuse_r[0], sut_fuse_r})
          3'b000: begin su_cycles = `CKSD_CK_258; rst_delay = 2'd1; end // [RULE_14]
          3'b001: begin su_cycles = `CKSD_CK_258; rst_delay = 2'd2; end // [RULE_14]
          3'b010: begin su_cycles = `CKSD_CK_1K; rst_delay = 2'd0; end // [RULE_14]
          3'b011: begin su_cycles = `CKSD_CK_1K; rst_delay = 2'd1; end // [RULE_14]
          3'b100: begin su_cycles = `CKSD_CK_1K; rst_delay = 2'd2; end // [RULE_15]
          3'b101: begin su_cycles = `CKSD_CK_16K; rst_delay = 2'd0; end // [RULE_15]
          3'b110: begin su_cycles = `CKSD_CK_16K; rst_delay = 2'd1; end // [RULE_15]
          default: begin su_cycles = `CKSD_CK_16K; rst_delay = 2'd2; end // [RULE_15]
        endcase
      end
      3'd3: begin
        su_cycles = (sut_fuse_r[1]) ? `CKSD_CK_32K : `CKSD_CK_1K;
        rst_delay = (sut_fuse_r == 2'b00) ? 2'd1 : 2'd2;
      end
      3'd2: begin
        su_cycles = (sut_fuse_r == 2'b11) ? `CKSD_CK_6 : `CKSD_CK_18;
        rst_delay = (sut_fuse_r == 2'b10) ? 2'd2 : {1'b0, |sut_fuse_r};
      end
      default: begin
        su_cycles = `CKSD_CK_6;
        rst_delay = (sut_fuse_r == 2'b00) ? 2'd0 : sut_fuse_r;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Divide control register; value only accepted with enable written one
  reg div_en_r;
  reg [6:0] div_val_r;
  wire wr_fire;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire wr_strb0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_en_r <= 1'b0;
      div_val_r <= 7'h00;
    end else if (wr_fire && wr_addr == `CKSD_ADDR_DIVCTL && wr_strb0) begin
      div_en_r <= wr_data[`CKSD_EN_BIT]; // [RULE_05]
      if (wr_data[`CKSD_EN_BIT] && !div_en_r) begin // [RULE_02]
        div_val_r <= wr_data[6:0]; // [RULE_03]
      end
      // Enable written zero leaves the value untouched [RULE_04]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider: one enable pulse per (129 - d) source edges, applied at the
  // end of a whole period so no shortened phase appears on a switch
  reg [7:0] div_cnt_r;
  reg div_act_r;
  reg [7:0] div_n_r;
  reg sys_tick_r;
  wire [7:0] div_n_cfg = `CKSD_DIV_BASE - {1'b0, div_val_r}; // [RULE_01]
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 8'h00;
      div_act_r <= 1'b0;
      div_n_r <= 8'h01;
      sys_tick_r <= 1'b0;
    end else begin
      sys_tick_r <= 1'b0;
      if (src_tick) begin
        if (div_cnt_r + 8'h01 >= div_n_r || !div_act_r) begin
          div_cnt_r <= 8'h00;
          sys_tick_r <= 1'b1;
          div_act_r <= div_en_r; // [RULE_20]
          div_n_r <= div_en_r ? div_n_cfg : 8'h01; // [RULE_01]
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start-up sequencer
  localparam [3:0] ST_RSTDLY = 4'b0001;
  localparam [3:0] ST_OSCSU = 4'b0010;
  localparam [3:0] ST_RUN = 4'b0100;
  localparam [3:0] ST_SLEEP = 4'b1000;
  reg [3:0] state_r;
  reg [16:0] cnt_r;
  reg from_reset_r;
  wire [16:0] wdt_target = (rst_delay == 2'd2) ? WDT_LONG : WDT_SHORT;
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_RSTDLY;
      cnt_r <= 17'h00000;
      from_reset_r <= 1'b1;
    end else begin
      case (state_r)
        ST_RSTDLY: begin
          // Reset delay counts watchdog oscillator edges [RULE_10]
          if (from_reset_r && rst_delay != 2'd0 && cnt_r < wdt_target) begin
            if (wdt_tick) cnt_r <= cnt_r + 17'h00001;
          end else begin
            cnt_r <= 17'h00000;
            from_reset_r <= 1'b0;
            state_r <= ST_OSCSU;
          end
        end
        ST_OSCSU: begin
          // Source edges time oscillator settling [RULE_09]
          if (cnt_r < {2'b00, su_cycles}) begin
            if (src_tick) cnt_r <= cnt_r + 17'h00001;
          end else begin
            cnt_r <= 17'h00000;
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleep_req) state_r <= ST_SLEEP;
        end
        default: begin
          if (wake_s_r[1]) state_r <= ST_RSTDLY; // [RULE_09]
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock domain enables; registered so every output has a clean reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_clk_en <= 1'b0;
      io_clk_en <= 1'b0;
      program_memory_clk_en <= 1'b0;
      converter_clk_en <= 1'b0;
      async_detect_en <= 1'b0;
      async_timer_clk_en <= 1'b0;
      full_swing_amp <= 1'b0;
      clock_source <= 3'd1;
      cpu_run <= 1'b0;
    end else begin
      cpu_run <= (state_r == ST_RUN);
      core_clk_en <= (state_r == ST_RUN) & ~adc_halt_req & sys_tick_r; // [RULE_01]
      io_clk_en <= (state_r == ST_RUN) & ~adc_halt_req & sys_tick_r;
      program_memory_clk_en <= (state_r == ST_RUN) & ~adc_halt_req & sys_tick_r; // [RULE_19]
      converter_clk_en <= (state_r == ST_RUN) & src_tick; // [RULE_18]
      async_detect_en <= (state_r != ST_RUN) | adc_halt_req; // [RULE_16]
      async_timer_clk_en <= 1'b1; // [RULE_17]
      full_swing_amp <= amp_programmed; // [RULE_12]
      clock_source <= src_class; // [RULE_07]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data taken in either order
  reg aw_hold_r;
  reg w_hold_r;
  reg [3:0] awaddr_r;
  reg [31:0] wdata_r;
  reg wstrb0_r;
  // Data taken ahead of the address must survive until the address arrives
  assign wr_data = w_hold_r ? wdata_r : s_axi_wdata;
  assign wr_strb0 = w_hold_r ? wstrb0_r : s_axi_wstrb[0];
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  wire aw_ok = aw_hold_r | (s_axi_awvalid & s_axi_awready);
  wire w_ok = w_hold_r | (s_axi_wvalid & s_axi_wready);
  assign wr_fire = aw_ok & w_ok & ~s_axi_bvalid;
  assign wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CKSD_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr == `CKSD_ADDR_DIVCTL) ? `CKSD_RESP_OKAY : `CKSD_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_r <= 1'b1;
          wdata_r <= s_axi_wdata;
          wstrb0_r <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; one cycle latency
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CKSD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CKSD_RESP_OKAY;
      if (s_axi_araddr == `CKSD_ADDR_DIVCTL) begin
        s_axi_rdata <= {24'h000000, div_en_r, div_val_r};
      end else if (s_axi_araddr == `CKSD_ADDR_STATUS) begin
        s_axi_rdata <= {20'h00000, div_n_r, state_r};
      end else if (s_axi_araddr == `CKSD_ADDR_FUSES) begin
        s_axi_rdata <= {21'h000000, amp_fuse_r, sut_fuse_r, src_fuse_r, 1'b0, src_class};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `CKSD_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### logic/cksd_defines.vh
// Constants for the clock source, divider and start-up controller
`ifndef CKSD_DEFINES_VH
`define CKSD_DEFINES_VH
// Summary of operation
// [RULE_01] With divide enabled, core/io/program clocks run at source over 129 minus value.
// [RULE_02] The 7-bit divide value changes only while divide-enable is zero.
// [RULE_03] Writing enable one takes the value written alongside as the factor.
// [RULE_04] Writing enable zero discards the value written alongside.
// [RULE_05] Divide-enable may be written at any time during operation.
// [RULE_06] Software keeps the async timer clock below a quarter of divided clock.
// [RULE_07] Source fuses pick crystal, low-freq crystal, external RC, internal RC, external clock.
// [RULE_08] A fuse bit reads one unprogrammed and zero programmed.
// [RULE_09] Wake from deep sleep waits configured source cycles before execution.
// [RULE_10] Reset start adds 4096 or 65536 watchdog oscillator cycles.
// [RULE_11] Delivered fuses: source 0001, start-up 10.
// [RULE_12] Amplifier fuse programmed gives full swing, unprogrammed reduced swing.
// [RULE_13] Crystal range fuses 101/110/111 pick frequency bands; programmed amp gives 1 MHz up.
// [RULE_14] Crystal, startup-select 0: 258+4K, 258+64K, 1K+none, 1K+4K.
// [RULE_15] Crystal, startup-select 1: 1K+64K, 16K+none, 16K+4K, 16K+64K.
// [RULE_16] Async interrupt and address detection stays alive while io clock halted.
// [RULE_17] Async timer runs from its own 32 kHz domain, kept during sleep.
// [RULE_18] Converter has its own clock domain so core and io may halt.
// [RULE_19] Program-memory clock gates together with the core clock.
// [RULE_20] Switching divided and undivided clock makes no short clock phases.
`define CKSD_ADDR_DIVCTL 4'h0
`define CKSD_ADDR_STATUS 4'h4
`define CKSD_ADDR_FUSES 4'h8
`define CKSD_DIVCTL_RST 8'h00
`define CKSD_EN_BIT 7
`define CKSD_DIV_BASE 8'd129
`define CKSD_SRC_DEFAULT 4'h1
`define CKSD_SUT_DEFAULT 2'h2
`define CKSD_WDT_SHORT 17'd4096
`define CKSD_WDT_LONG 17'd65536
`define CKSD_CK_6 15'd6
`define CKSD_CK_18 15'd18
`define CKSD_CK_258 15'd258
`define CKSD_CK_1K 15'd1024
`define CKSD_CK_16K 15'd16384
`define CKSD_CK_32K 15'd32767
`define CKSD_RESP_OKAY 2'b00
`define CKSD_RESP_SLVERR 2'b10
`endif

// ### sim/cksd_osc_model.sv
// Free-running source oscillator and watchdog oscillator
`timescale 1ns/1ns
module cksd_osc_model (
  output logic src_clk,
  output logic wdt_clk
);
  // Source period 240 ns, phase unrelated to the bus clock
  initial begin
    src_clk = 1'b0;
    #7;
    forever #120 src_clk = ~src_clk;
  end
  // Watchdog oscillator period 400 ns, a second unrelated phase
  initial begin
    wdt_clk = 1'b0;
    #13;
    forever #200 wdt_clk = ~wdt_clk;
  end
endmodule

// ### sim/cksd_props.sv
// Assertion checker for the clock controller ports
`timescale 1ns/1ns
module cksd_props #(
  parameter [3:0] SRC_FUSE_INIT = 4'h1,
  parameter AMP_FUSE_INIT = 1'b1
) (
  input wire aclk,
  input wire aresetn,
  input wire adc_halt_req,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire core_clk_en,
  input wire io_clk_en,
  input wire program_memory_clk_en,
  input wire async_detect_en,
  input wire async_timer_clk_en,
  input wire full_swing_amp,
  input wire [2:0] clock_source,
  input wire cpu_run
);
  // Source class the latched fuse value must give
  localparam [2:0] SRC_CLASS = (SRC_FUSE_INIT == 4'h0) ? 3'h0 : (SRC_FUSE_INIT < 4'h5) ? 3'h1 :
    (SRC_FUSE_INIT < 4'h9) ? 3'h2 : (SRC_FUSE_INIT == 4'h9) ? 3'h3 : 3'h4;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken on one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Halt held long enough for the registered enables to follow
  sequence s_halt_held;
    adc_halt_req [*3];
  endsequence
  AST_WR_ANSWER: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_IO_CORE: assert property (io_clk_en == core_clk_en)
    else $error("io and core enables differ");
  AST_FLASH_GATE: assert property (program_memory_clk_en == core_clk_en)
    else $error("program memory enable not with core");
  AST_ADC_HALT: assert property (s_halt_held |-> !core_clk_en && async_detect_en)
    else $error("core clock runs during converter halt");
  AST_ASYNC_DET: assert property (!cpu_run [*3] |-> async_detect_en)
    else $error("async detection off while halted");
  AST_ASY_CLK: assert property ($past(aresetn) |-> async_timer_clk_en)
    else $error("async timer clock off");
  AST_AMP: assert property (cpu_run |-> full_swing_amp == !AMP_FUSE_INIT)
    else $error("amplifier mode wrong");
  AST_SRC: assert property (cpu_run |-> clock_source == SRC_CLASS)
    else $error("clock source class wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cksd_clock_control cksd_props #(.SRC_FUSE_INIT(SRC_FUSE_INIT), .AMP_FUSE_INIT(AMP_FUSE_INIT))
  u_props (.aclk, .aresetn, .adc_halt_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .core_clk_en, .io_clk_en, .program_memory_clk_en,
  .async_detect_en, .async_timer_clk_en, .full_swing_amp, .clock_source, .cpu_run);

// ### sim/testbench.sv
// Self-checking bench for the clock controller
`timescale 1ns/1ns
module testbench;
  logic aclk, aresetn, src_clk_in, wdt_osc_in, wake_req, sleep_req, adc_halt_req;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic core_clk_en, io_clk_en, program_memory_clk_en, converter_clk_en, async_detect_en;
  logic async_timer_clk_en, full_swing_amp, cpu_run;
  logic [2:0] clock_source;
  int n_errors = 0, checks = 0, n, g;
  // Short watchdog counts keep the reset delay brief
  cksd_clock_control #(.WDT_SHORT(17'd8), .WDT_LONG(17'd16)) u_dut (.aclk, .aresetn,
    .src_clk_in, .wdt_osc_in, .wake_req, .sleep_req, .adc_halt_req, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_clk_en, .io_clk_en,
    .program_memory_clk_en, .converter_clk_en, .async_detect_en, .async_timer_clk_en,
    .full_swing_amp, .clock_source, .cpu_run);
  cksd_osc_model u_osc (.src_clk(src_clk_in), .wdt_clk(wdt_osc_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Bus clock, 40 ns period
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A used-up wait counts as a failure and ends the run
  task automatic limit(input int k);
    if (k >= 4000) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && k < 4000);
    while (!s_axi_bvalid && k < 4000) begin
      @(posedge aclk);
      k++;
    end
    s_axi_bready <= 1'b0;
    limit(k);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_arready && k < 4000);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && k < 4000) begin
      @(posedge aclk);
      k++;
    end
    s_axi_rready <= 1'b0;
    limit(k);
    chk(s_axi_rdata, v);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  // Gap between the second and third core pulses; the first may carry the old ratio
  task automatic span(input int e);
    int k;
    int c;
    c = 0;
    g = 0;
    for (k = 0; k < 4000 && c < 3; k++) begin
      @(posedge aclk);
      g++;
      if (core_clk_en) begin
        c++;
        if (c < 3) g = 0;
      end
    end
    limit(k);
    chk(g, e);
  endtask
  task automatic wait_run(input logic lvl);
    n = 0;
    while (cpu_run !== lvl && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    limit(n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; source period is 6 bus cycles
  // No timer traffic here, so the async clock limit is never stressed
  initial begin
    {aresetn, wake_req, sleep_req, adc_halt_req, s_axi_awvalid, s_axi_wvalid} = 6'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run(1'b1);
    chk(n >= 175 && n <= 215, 1);
    rd(4'h8, 32'h611, 2'b00);
    rd(4'h0, 32'h0, 2'b00);
    rd(4'h4, 32'h14, 2'b00);
    span(6);
    wr(4'h0, 32'hff, 2'b00);
    rd(4'h0, 32'hff, 2'b00);
    span(12);
    wr(4'h0, 32'h80, 2'b00);
    rd(4'h0, 32'hff, 2'b00);
    wr(4'h0, 32'h05, 2'b00);
    rd(4'h0, 32'h7f, 2'b00);
    span(6);
    wr(4'h0, 32'hfe, 2'b00);
    span(18);
    wr(4'h0, 32'h00, 2'b00);
    wr(4'h0, 32'h80, 2'b00);
    rd(4'h0, 32'h80, 2'b00);
    span(774);
    rd(4'h4, 32'h814, 2'b00);
    wr(4'h0, 32'h00, 2'b00);
    wr(4'hc, 32'h1, 2'b10);
    wr(4'h4, 32'h1, 2'b10);
    rd(4'hc, 32'h0, 2'b10);
    // Converter keeps pulsing while the core is halted
    adc_halt_req <= 1'b1;
    g = 0;
    repeat (60) begin
      @(posedge aclk);
      if (converter_clk_en) g++;
    end
    chk(g > 4, 1);
    adc_halt_req <= 1'b0;
    sleep_req <= 1'b1;
    wait_run(1'b0);
    sleep_req <= 1'b0;
    wake_req <= 1'b1;
    wait_run(1'b1);
    chk(n >= 28 && n <= 48, 1);
    wake_req <= 1'b0;
    repeat (5) @(posedge aclk);
    complete_run();
  end
endmodule
